// ### core/bsr_seq.v
// Purpose: cold reset, strap capture and boot release sequencer
// Assumes: board keeps strap levels stable around cold release
// Notes:   registers reached over AXI4-Lite, 32-bit words
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "bsr_consts.vh"

module bsr_seq (
  input  wire        ref_clk,
  input  wire        sys_rst,
  // board pins
  input  wire        cold_reset_n_pin,
  input  wire        pci_reset_n_pin,
  input  wire [2:0]  pcst_strap_in,
  input  wire [3:0]  debug_strap_in,
  input  wire [22:17] mem_addr_in,
  output wire        mem_addr_hi_oe,
  output wire        mem_bus_oe,
  output wire        eeprom_bus_oe,
  output wire        debug_oe,
  // core side
  output wire        core_reset_n,
  output wire        boot_fetch,
  output wire [31:0] boot_addr,
  output wire [1:0]  boot_cs,
  output wire [5:0]  boot_wait_states,
  output wire [9:0]  core_config_bits,
  output wire [2:0]  pipeline_clock_mult,
  output wire        byte_order_bit,
  output wire        timer_irq_enable_strap,
  output wire [5:0]  boot_port_width,
  output wire        pci_satellite,
  output wire        pci_boot,
  output wire        strap_unsupported,
  output wire        eeprom_load_req,
  input  wire        eeprom_load_done,
  output wire        pci_if_enable,
  // axi4-lite slave
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready
);

  localparam S_COLD = 3'h0;
  localparam S_CAPC = 3'h1;
  localparam S_CAPS = 3'h2;
  localparam S_HOLD = 3'h3;
  localparam S_REL  = 3'h4;
  localparam S_RUN  = 3'h5;
  localparam S_PCIR = 3'h6;

  // =========================================================
  // decoders
  function [2:0] mult_of;
    input [2:0] code;
    begin
      case (code)
        3'h0:    mult_of = 3'h2;
        3'h1:    mult_of = 3'h3;
        3'h2:    mult_of = 3'h4;
        default: mult_of = 3'h0; // reserved codes
      endcase
    end
  endfunction

  function [5:0] width_of;
    input [1:0] code;
    begin
      case (code)
        2'h0:    width_of = 6'h08;
        2'h1:    width_of = 6'h10;
        2'h2:    width_of = 6'h20;
        default: width_of = 6'h00; // reserved code
      endcase
    end
  endfunction

  // =========================================================
  // pin synchronisers
  wire        cold_n_s;
  wire        pci_n_s;
  wire [2:0]  pcst_s;
  wire [3:0]  dbg_s;
  wire [5:0]  addr_s;

  bsr_sync #(.W(2), .INIT(1'b0)) u_rst_sync (
    .clk (ref_clk),
    .rst (sys_rst),
    .d   ({cold_reset_n_pin, pci_reset_n_pin}),
    .q   ({cold_n_s, pci_n_s})
  );

  bsr_sync #(.W(13), .INIT(1'b0)) u_strap_sync (
    .clk (ref_clk),
    .rst (sys_rst),
    .d   ({pcst_strap_in, debug_strap_in, mem_addr_in}),
    .q   ({pcst_s, dbg_s, addr_s})
  );

  // =========================================================
  // sequencer state
  reg [2:0]  state_reg;
  reg [2:0]  state_next;
  reg [8:0]  cnt_reg;
  reg [8:0]  cnt_next;
  reg [9:0]  core_bits_reg;
  reg [2:0]  sys_bits_reg;
  reg        core_rst_n_reg;
  reg        fetch_reg;
  reg        addr_oe_reg;
  reg        bus_oe_reg;
  reg        dbg_oe_reg;
  reg        eeprom_done_reg;
  reg        host_cfg_done_reg;

  wire float_live = (addr_s[5:4] == `BSR_STRAP_FLOAT);
  wire strap_pci  = (sys_bits_reg[2:1] == `BSR_STRAP_PCI);
  wire strap_std  = (sys_bits_reg[2:1] == `BSR_STRAP_STD);
  wire pci_mode   = strap_pci & sys_bits_reg[0];
  wire hold_end   = (cnt_reg == `BSR_HOLD_CYCLES - 9'h001);
  wire rel_end    = (cnt_reg[1:0] == `BSR_DRIVE_DELAY - 2'h1);

  // next state; cold reset wins over everything else
  always @* begin
    state_next = state_reg;
    cnt_next   = cnt_reg + 9'h001;
    case (state_reg)
      S_COLD: begin
        cnt_next = 9'h000;
        if (cold_n_s)
          state_next = S_CAPC;
      end
      S_CAPC: state_next = S_CAPS;
      S_CAPS: state_next = S_HOLD;
      S_HOLD: begin
        if (hold_end) begin
          state_next = S_REL;
          cnt_next   = 9'h000;
        end
      end
      S_REL: begin
        if (rel_end)
          state_next = S_RUN;
      end
      S_RUN:  cnt_next = 9'h000;
      S_PCIR: begin
        cnt_next = 9'h000;
        if (pci_n_s)
          state_next = S_HOLD;
      end
      default: state_next = S_COLD;
    endcase
    // pci reset restarts the core only in pci boot mode
    if (pci_mode && !pci_n_s && (state_reg == S_HOLD ||
        state_reg == S_REL || state_reg == S_RUN)) begin
      state_next = S_PCIR;
      cnt_next   = 9'h000;
    end
    if (!cold_n_s) begin
      state_next = S_COLD;
      cnt_next   = 9'h000;
    end
  end

  // state, counters and strap captures
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg     <= S_COLD;
      cnt_reg       <= 9'h000;
      core_bits_reg <= 10'h000;
      sys_bits_reg  <= 3'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      // core bits first, system bits one cycle later
      if (state_reg == S_CAPC)
        core_bits_reg <= {addr_s[2:0], dbg_s, pcst_s};
      if (state_reg == S_CAPS)
        sys_bits_reg <= addr_s[5:3];
    end
  end

  // =========================================================
  // pin enables and core release, all registered
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      core_rst_n_reg <= 1'b0;
      fetch_reg      <= 1'b0;
      addr_oe_reg    <= 1'b0;
      bus_oe_reg     <= 1'b0;
      dbg_oe_reg     <= 1'b0;
    end else begin
      // low in every state before the release
      core_rst_n_reg <= (state_next == S_REL) |
                        (state_next == S_RUN);
      fetch_reg      <= (state_reg == S_HOLD) &
                        (state_next == S_REL);
      // strap lines stay free until the 2nd clock after
      addr_oe_reg    <= (state_next == S_RUN);
      // float strap applies while cold reset is held
      bus_oe_reg     <= !((state_next == S_COLD) &
                          float_live);
      dbg_oe_reg     <= (state_next != S_COLD);
    end
  end

  // =========================================================
  // pci role and eeprom load
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      eeprom_done_reg <= 1'b0;
    end else if (state_reg != S_RUN) begin
      eeprom_done_reg <= 1'b0;
    end else if (eeprom_load_done) begin
      eeprom_done_reg <= 1'b1;
    end
  end

  // read-only pci config comes from eeprom in pci boot
  assign eeprom_load_req = pci_mode & (state_reg == S_RUN) &
                           !eeprom_done_reg;
  // host role waits for software to finish config writes
  assign pci_if_enable = (state_reg == S_RUN) &
                         (pci_mode ? eeprom_done_reg :
                          pci_satellite ? 1'b1 :
                          host_cfg_done_reg);
  assign pci_boot      = pci_mode;
  // bit 20 selects satellite in both boot modes
  assign pci_satellite = sys_bits_reg[0] &
                         (strap_pci | strap_std);
  // board must avoid these; flagged, not acted on
  assign strap_unsupported =
    (sys_bits_reg[2:1] == `BSR_STRAP_RSVD) |
    (strap_pci & !sys_bits_reg[0]);

  // =========================================================
  // decoded core config
  assign core_config_bits       = core_bits_reg;
  assign pipeline_clock_mult    =
    mult_of(core_bits_reg[`BSR_MULT_LSB +: 3]);
  assign byte_order_bit         = core_bits_reg[`BSR_ORDER_BIT];
  assign timer_irq_enable_strap = !core_bits_reg[`BSR_TIMER_BIT];
  assign boot_port_width        =
    width_of(core_bits_reg[`BSR_WIDTH_LSB +: 2]);

  assign core_reset_n     = core_rst_n_reg;
  assign boot_fetch       = fetch_reg;
  assign boot_addr        = `BSR_BOOT_ADDR;
  assign boot_cs          = `BSR_BOOT_CS;
  assign boot_wait_states = `BSR_BOOT_WAITS;
  assign mem_addr_hi_oe   = addr_oe_reg;
  assign mem_bus_oe       = bus_oe_reg;
  assign eeprom_bus_oe    = bus_oe_reg;
  assign debug_oe         = dbg_oe_reg;

  // =========================================================
  // axi4-lite write path; address and data in either order
  reg        aw_got_reg;
  reg        w_got_reg;
  reg [3:0]  aw_addr_reg;
  reg [31:0] w_data_reg;
  reg        w_lane0_reg;
  reg        bvalid_reg;
  reg [1:0]  bresp_reg;
  wire       aw_hs = s_axi_awvalid & !aw_got_reg & !bvalid_reg;
  wire       w_hs  = s_axi_wvalid & !w_got_reg & !bvalid_reg;
  wire       wr_go = aw_got_reg & w_got_reg & !bvalid_reg;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      aw_got_reg        <= 1'b0;
      w_got_reg         <= 1'b0;
      aw_addr_reg       <= 4'h0;
      w_data_reg        <= 32'h0000_0000;
      w_lane0_reg       <= 1'b0;
      bvalid_reg        <= 1'b0;
      bresp_reg         <= `BSR_RESP_OKAY;
      host_cfg_done_reg <= `BSR_CTRL_RST;
    end else begin
      if (aw_hs) begin
        aw_got_reg  <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_got_reg   <= 1'b1;
        w_data_reg  <= s_axi_wdata;
        w_lane0_reg <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_got_reg <= 1'b0;
        w_got_reg  <= 1'b0;
        bvalid_reg <= 1'b1;
        if (aw_addr_reg[3:2] == `BSR_ADDR_CTRL >> 2) begin
          bresp_reg <= `BSR_RESP_OKAY;
          if (w_lane0_reg)
            host_cfg_done_reg <= w_data_reg[0];
        end else if (aw_addr_reg[3:2] == `BSR_ADDR_STATUS >> 2 ||
                     aw_addr_reg[3:2] == `BSR_ADDR_BOOT >> 2) begin
          bresp_reg <= `BSR_RESP_OKAY; // read-only, write ignored
        end else begin
          bresp_reg <= `BSR_RESP_SLVERR;
        end
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
      // a cold reset drops the software handshake
      if (state_reg == S_COLD)
        host_cfg_done_reg <= `BSR_CTRL_RST;
    end
  end

  assign s_axi_awready = !aw_got_reg & !bvalid_reg;
  assign s_axi_wready  = !w_got_reg & !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  // =========================================================
  // axi4-lite read path, one cycle after the address
  reg        rvalid_reg;
  reg [31:0] rdata_reg;
  reg [1:0]  rresp_reg;
  wire       ar_hs = s_axi_arvalid & !rvalid_reg;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= `BSR_RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= `BSR_RESP_OKAY;
      case (s_axi_araddr[3:2])
        `BSR_ADDR_STATUS >> 2:
          rdata_reg <= {8'h00, state_reg, pci_if_enable,
                        strap_unsupported, pci_satellite,
                        pci_mode, core_rst_n_reg, 3'h0,
                        sys_bits_reg, core_bits_reg};
        `BSR_ADDR_CTRL >> 2:
          rdata_reg <= {31'h0000_0000, host_cfg_done_reg};
        `BSR_ADDR_BOOT >> 2:
          rdata_reg <= `BSR_BOOT_ADDR;
        default: begin
          rdata_reg <= 32'h0000_0000;
          rresp_reg <= `BSR_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

endmodule

`default_nettype wire

// ### shared/bsr_consts.vh
// Purpose: constants for the boot strap and reset sequencer
// Assumes: one 40 MHz clock, synchronous active-high reset
// Notes:   all counts are in ref_clk cycles
// Overview of operation
// - strap 11 floats memory and eeprom buses during cold reset
// - strap 01 with bit20 high: pci boot
// - strap 00, bit20 high: standard boot, satellite
// - strap 00, bit20 low: standard boot, host
// - pci boot loads read-only config from eeprom
// - capture core bits, then system bits
// - core reset held exactly 256 cycles
// - first fetch 0x1fc0_0000, cs0, 32 waits
// - address 22:17 float until 2nd clock after
// - debug outputs float during cold reset
// - core bits captured on cold reset release
// - bits 2:0 choose clock multiplier
// - bit3 byte order, bit6 timer irq disable
// - bits 9:8 choose boot port width
`ifndef BSR_CONSTS_VH
`define BSR_CONSTS_VH

// ==========================================================
// timing
`define BSR_HOLD_CYCLES   9'h100
`define BSR_CAP_CYCLES    9'h002
`define BSR_DRIVE_DELAY   2'h2

// ==========================================================
// boot fetch
`define BSR_BOOT_ADDR     32'h1fc0_0000
`define BSR_BOOT_WAITS    6'h20
`define BSR_BOOT_CS       2'h0

// ==========================================================
// strap patterns on address 22:21
`define BSR_STRAP_FLOAT   2'h3
`define BSR_STRAP_RSVD    2'h2
`define BSR_STRAP_PCI     2'h1
`define BSR_STRAP_STD     2'h0

// ==========================================================
// core config field positions
`define BSR_MULT_LSB      0
`define BSR_ORDER_BIT     3
`define BSR_TIMER_BIT     6
`define BSR_WIDTH_LSB     8

// ==========================================================
// register map (byte addresses)
`define BSR_ADDR_STATUS   4'h0
`define BSR_ADDR_CTRL     4'h4
`define BSR_ADDR_BOOT     4'h8
`define BSR_CTRL_RST      1'h0
`define BSR_RESP_OKAY     2'h0
`define BSR_RESP_SLVERR   2'h2

`endif

// ### core/bsr_sync.v
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs are quasi-static or slow against ref_clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none

module bsr_sync #(
  parameter W    = 1,
  parameter INIT = 1'b0
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);

  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  // =========================================================
  // two stages, cleared to a constant under reset
  always @(posedge clk) begin
    if (rst) begin
      meta_reg <= {W{INIT}};
      sync_reg <= {W{INIT}};
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;

endmodule

`default_nettype wire

// ### tb/bsr_seq_monitor.sv
// Purpose: port checker for the boot strap and reset sequencer
// Assumes: one ref_clk domain, sys_rst synchronous active high
// Notes:   bound to every bsr_seq instance, sees its ports only
`timescale 1ns/1ps
`default_nettype none

module bsr_seq_monitor (
  input wire         ref_clk,
  input wire         sys_rst,
  input wire         cold_reset_n_pin,
  input wire         pci_reset_n_pin,
  input wire [22:17] mem_addr_in,
  input wire         mem_addr_hi_oe,
  input wire         mem_bus_oe,
  input wire         eeprom_bus_oe,
  input wire         debug_oe,
  input wire         core_reset_n,
  input wire         boot_fetch,
  input wire [31:0]  boot_addr,
  input wire [1:0]   boot_cs,
  input wire [5:0]   boot_wait_states,
  input wire [9:0]   core_config_bits,
  input wire [2:0]   pipeline_clock_mult,
  input wire         byte_order_bit,
  input wire         timer_irq_enable_strap,
  input wire [5:0]   boot_port_width
);
  // ==========================================================
  // helper logic
  logic [9:0] hold_cnt;
  logic       pci_seen;

  // low cycles since the cold release; a pci reset spoils the count
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !debug_oe) begin
      hold_cnt <= 10'h000;
      pci_seen <= 1'b0;
    end else begin
      if (!core_reset_n)
        hold_cnt <= hold_cnt + 10'h001;
      if (!pci_reset_n_pin)
        pci_seen <= 1'b1;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // ==========================================================
  // sequences and assertions
  // four samples flush the two-stage pin synchroniser
  sequence cold_held;
    !cold_reset_n_pin [*4];
  endsequence
  sequence float_held;
    (!cold_reset_n_pin && mem_addr_in[22:21] == 2'b11) [*4];
  endsequence
  sequence fetch_pulse;
    boot_fetch ##1 !boot_fetch;
  endsequence

  chk_hold_exact: assert property (
    $rose(core_reset_n) && !pci_seen |-> hold_cnt == 10'h100)
    else $error("core reset low time is not 256 cycles");
  chk_fetch_release: assert property (
    $rose(core_reset_n) |-> fetch_pulse)
    else $error("boot fetch pulse missing at core release");
  chk_fetch_target: assert property (
    boot_fetch |-> boot_addr == 32'h1fc0_0000 && boot_cs == 2'h0
      && boot_wait_states == 6'h20)
    else $error("boot fetch target wrong");
  chk_addr_quiet: assert property (
    !core_reset_n |-> !mem_addr_hi_oe)
    else $error("address lines driven during core reset");
  chk_addr_late: assert property (
    $rose(mem_addr_hi_oe) |-> $past(core_reset_n, 2)
      && !$past(core_reset_n, 3))
    else $error("address drive not on second clock after release");
  chk_debug_float: assert property (
    cold_held |=> !debug_oe && !core_reset_n)
    else $error("debug pins driven during cold reset");
  chk_bus_float: assert property (
    float_held |=> !mem_bus_oe && !eeprom_bus_oe)
    else $error("memory or eeprom bus driven under float strap");
  chk_mult_decode: assert property (
    pipeline_clock_mult == (core_config_bits[2:0] < 3'h3 ?
      core_config_bits[2:0] + 3'h2 : 3'h0))
    else $error("clock multiplier decode wrong");
  chk_order_timer: assert property (
    byte_order_bit == core_config_bits[3]
      && timer_irq_enable_strap == !core_config_bits[6])
    else $error("byte order or timer enable decode wrong");
  chk_width_decode: assert property (
    boot_port_width == (core_config_bits[9] ?
      (core_config_bits[8] ? 6'h00 : 6'h20) :
      (core_config_bits[8] ? 6'h10 : 6'h08)))
    else $error("boot port width decode wrong");
  chk_bits_frozen: assert property (
    core_reset_n |-> $stable(core_config_bits))
    else $error("core bits changed after capture");
endmodule

bind bsr_seq bsr_seq_monitor u_mon (.ref_clk, .sys_rst, .cold_reset_n_pin,
  .pci_reset_n_pin, .mem_addr_in, .mem_addr_hi_oe, .mem_bus_oe,
  .eeprom_bus_oe, .debug_oe, .core_reset_n, .boot_fetch, .boot_addr,
  .boot_cs, .boot_wait_states, .core_config_bits, .pipeline_clock_mult,
  .byte_order_bit, .timer_irq_enable_strap, .boot_port_width);

`default_nettype wire

// ### tb/bsr_board_model.sv
// Purpose: board side, cold and pci reset sources plus strap pulls
// Assumes: bench sets the wanted levels by non-blocking assignment
// Notes:   bad_ok lets a scenario present unsupported straps
`timescale 1ns/1ps
`default_nettype none

module bsr_board_model (
  input  wire logic [2:0]  sys_strap,
  input  wire logic [9:0]  core_strap,
  input  wire logic        cold_req,
  input  wire logic        pci_req,
  input  wire logic        bad_ok,
  input  wire logic        mem_addr_hi_oe,
  input  wire logic        debug_oe,
  output logic             cold_reset_n_pin,
  output logic             pci_reset_n_pin,
  output logic [2:0]       pcst_strap_in,
  output logic [3:0]       debug_strap_in,
  output logic [22:17]     mem_addr_in
);
  logic [2:0] sys_fix;

  // a sane board never fits the forbidden strap patterns
  always_comb begin
    sys_fix = sys_strap;
    if (!bad_ok && sys_fix[2:1] == 2'b01)
      sys_fix[0] = 1'b1;
    if (!bad_ok && sys_fix[2:1] == 2'b10)
      sys_fix = 3'b000;
  end

  // pulls hold the levels; once the chip drives, lines show other data
  assign mem_addr_in = mem_addr_hi_oe ? ~{sys_fix, core_strap[9:7]}
                                      : {sys_fix, core_strap[9:7]};
  assign debug_strap_in = debug_oe ? ~core_strap[6:3]
                                   : core_strap[6:3];
  assign pcst_strap_in = core_strap[2:0];
  assign cold_reset_n_pin = !cold_req;
  assign pci_reset_n_pin = !pci_req;
endmodule

`default_nettype wire

// ### tb/boot_strap_reset_sequencer_test.sv
// Purpose: self-checking bench for the boot strap reset sequencer
// Assumes: 40 MHz ref_clk, reset held for eight cycles
// Notes:   each case strap-boots the part and checks decode and bus
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) \
  begin samples_checked++; if ((got) !== (exp)) begin err_count++; \
  $display("unexpected %s exp=%h got=%h", nm, exp, got); end end

module boot_strap_reset_sequencer_test;
  // ==========================================================
  // stimulus and wiring
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [2:0]  sys_strap = 3'h0;
  logic [9:0]  core_strap = 10'h000;
  logic        cold_req = 1'b1;
  logic        pci_req = 1'b0;
  logic        bad_ok = 1'b0;
  logic        eeprom_load_done = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0;
  logic [3:0]  s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic [31:0] rdata_q;
  logic [1:0]  resp_q;
  int          err_count = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  wire logic [2:0]   pcst_strap_in, pipeline_clock_mult;
  wire logic [3:0]   debug_strap_in;
  wire logic [22:17] mem_addr_in;
  wire logic [31:0]  boot_addr, s_axi_rdata;
  wire logic [1:0]   boot_cs, s_axi_bresp, s_axi_rresp;
  wire logic [5:0]   boot_wait_states, boot_port_width;
  wire logic [9:0]   core_config_bits;
  wire logic cold_reset_n_pin, pci_reset_n_pin, mem_addr_hi_oe, mem_bus_oe;
  wire logic eeprom_bus_oe, debug_oe, core_reset_n, boot_fetch;
  wire logic byte_order_bit, timer_irq_enable_strap, pci_satellite;
  wire logic pci_boot, strap_unsupported, eeprom_load_req, pci_if_enable;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire logic s_axi_rvalid;
  logic [12:0] cases [6] = '{{3'b001, 10'h208}, {3'b000, 10'h141},
    {3'b011, 10'h002}, {3'b111, 10'h307}, {3'b100, 10'h005},
    {3'b010, 10'h0fe}};

  bsr_board_model u_board (.sys_strap, .core_strap, .cold_req, .pci_req,
    .bad_ok, .mem_addr_hi_oe, .debug_oe, .cold_reset_n_pin,
    .pci_reset_n_pin, .pcst_strap_in, .debug_strap_in, .mem_addr_in);

  bsr_seq u_dut (.ref_clk, .sys_rst, .cold_reset_n_pin, .pci_reset_n_pin,
    .pcst_strap_in, .debug_strap_in, .mem_addr_in, .mem_addr_hi_oe,
    .mem_bus_oe, .eeprom_bus_oe, .debug_oe, .core_reset_n, .boot_fetch,
    .boot_addr, .boot_cs, .boot_wait_states, .core_config_bits,
    .pipeline_clock_mult, .byte_order_bit, .timer_irq_enable_strap,
    .boot_port_width, .pci_satellite, .pci_boot, .strap_unsupported,
    .eeprom_load_req, .eeprom_load_done, .pci_if_enable, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  // clock and hang guard; a hang counts as a mismatch
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 8000) begin
      err_count++;
      summarize;
    end
  end

  // ==========================================================
  // bus tasks, each channel held until its own ready
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    @(posedge ref_clk);
    while (s_axi_awvalid || s_axi_wvalid || s_axi_bready) begin
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        s_axi_bready <= 1'b0;
        resp_q = s_axi_bresp;
      end
      @(posedge ref_clk);
    end
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge ref_clk);
    while (s_axi_arvalid || s_axi_rready) begin
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        s_axi_rready <= 1'b0;
        rdata_q = s_axi_rdata;
        resp_q = s_axi_rresp;
      end
      @(posedge ref_clk);
    end
  endtask

  // ==========================================================
  // boot sequence tasks
  task automatic wait_rel;
    for (int n = 0; n < 300 && core_reset_n !== 1'b1; n++) begin
      @(posedge ref_clk);
      #1;
    end
    `CHK("core_rst", 1'b1, core_reset_n)
    `CHK("fetch", 1'b1, boot_fetch)
    `CHK("boot_addr", 32'h1fc0_0000, boot_addr)
    `CHK("addr_oe_fetch", 1'b0, mem_addr_hi_oe)
    `CHK("debug_on", 1'b1, debug_oe)
    @(posedge ref_clk);
    #1;
    `CHK("fetch_end", 1'b0, boot_fetch)
    @(posedge ref_clk);
    #1;
    `CHK("addr_oe_on", 1'b1, mem_addr_hi_oe)
  endtask

  task automatic run_case(input logic [12:0] v, input logic bad);
    logic [2:0] s;
    logic [9:0] c;
    logic       pb;
    s = v[12:10];
    c = v[9:0];
    pb = (s == 3'b011);
    @(posedge ref_clk);
    sys_strap <= s;
    core_strap <= c;
    bad_ok <= bad;
    cold_req <= 1'b1;
    repeat (6) @(posedge ref_clk);
    #1;
    `CHK("bus_oe", s[2:1] != 2'b11, mem_bus_oe)
    `CHK("eeprom_oe", s[2:1] != 2'b11, eeprom_bus_oe)
    `CHK("debug_oe", 1'b0, debug_oe)
    `CHK("addr_oe_cold", 1'b0, mem_addr_hi_oe)
    @(posedge ref_clk);
    cold_req <= 1'b0;
    repeat (250) @(posedge ref_clk);
    #1;
    `CHK("core_rst_early", 1'b0, core_reset_n)
    wait_rel;
    `CHK("core_bits", c, core_config_bits)
    `CHK("mult", c[2:0] < 3'h3 ? c[2:0] + 3'h2 : 3'h0,
         pipeline_clock_mult)
    `CHK("order", c[3], byte_order_bit)
    `CHK("timer_en", !c[6], timer_irq_enable_strap)
    `CHK("width", c[9] ? (c[8] ? 6'h00 : 6'h20) : (c[8] ? 6'h10 : 6'h08),
         boot_port_width)
    `CHK("pci_boot", pb, pci_boot)
    `CHK("satellite", s[0] && !s[2], pci_satellite)
    `CHK("unsupp", s[2:1] == 2'b10 || s == 3'b010, strap_unsupported)
    `CHK("eeprom_req", pb, eeprom_load_req)
    `CHK("pci_en", s == 3'b001, pci_if_enable)
    rd(4'h0);
    `CHK("status", {s, c}, rdata_q[12:0])
    if (pb) begin
      @(posedge ref_clk);
      eeprom_load_done <= 1'b1;
      @(posedge ref_clk);
      eeprom_load_done <= 1'b0;
    end
    wr(4'h4, 32'h1);
    `CHK("wr_resp", 2'h0, resp_q)
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK("pci_en_cfg", 1'b1, pci_if_enable)
    `CHK("eeprom_req_end", 1'b0, eeprom_load_req)
    // pci reset restarts the core only in pci boot
    @(posedge ref_clk);
    pci_req <= 1'b1;
    repeat (5) @(posedge ref_clk);
    #1;
    `CHK("pci_rst_core", !pb, core_reset_n)
    `CHK("pci_rst_addr", !pb, mem_addr_hi_oe)
    @(posedge ref_clk);
    pci_req <= 1'b0;
    if (pb) wait_rel;
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      run_case(cases[i], i >= 4);
      $display("test %0d done", i);
    end
    rd(4'h8);
    `CHK("boot_reg", 32'h1fc0_0000, rdata_q)
    rd(4'hc);
    `CHK("unmapped_resp", 2'h2, resp_q)
    wr(4'hc, 32'h0);
    `CHK("unmapped_wr", 2'h2, resp_q)
    $display("test register map done");
    summarize;
  end
endmodule

`default_nettype wire
